// File: src/eic_pkg.sv
// constants and types for the event interrupt and oscillator control block
package eic_pkg;
  localparam logic [7:0] EIC_OP_WRITE = 8'h42;
  localparam logic [7:0] EIC_OP_READ = 8'hC2;
  localparam logic [15:0] EIC_REG_RESET = 16'h0000;
  localparam logic [15:0] EIC_REG_MASK = 16'h0FFF;
  localparam int EIC_OPC_BITS = 8;
  localparam int EIC_FRAME_BITS = 24;
  localparam int EIC_BIT_MON_EN = 11;
  localparam int EIC_BIT_MON_SEL = 10;
  localparam int EIC_BIT_IRQ_EN = 9;
  localparam int EIC_BIT_REPEAT = 8;
  localparam int EIC_BIT_PER_CYCLE = 7;
  localparam int EIC_SETTLE_LSB = 4;
  localparam logic [7:0] EIC_SETTLE_0 = 8'h10;
  localparam logic [7:0] EIC_SETTLE_1 = 8'h30;
  localparam logic [7:0] EIC_SETTLE_2 = 8'h60;
  localparam logic [7:0] EIC_SETTLE_3 = 8'h80;
  localparam logic [7:0] EIC_SETTLE_4 = 8'hA8;
  localparam logic [2:0] EIC_SETTLE_MAX_TIMED = 3'h4;

  typedef enum logic [1:0]
  {
    EIC_IDLE = 2'b00,
    EIC_SETTLE = 2'b01,
    EIC_MEASURE = 2'b10
  } eic_state_t;

  function automatic logic [7:0] eic_settle_len(input logic [2:0] code);
    logic [7:0] n;
    n = EIC_SETTLE_4;
    case (code)
      3'h0: n = EIC_SETTLE_0;
      3'h1: n = EIC_SETTLE_1;
      3'h2: n = EIC_SETTLE_2;
      3'h3: n = EIC_SETTLE_3;
      default: n = EIC_SETTLE_4;
    endcase
    return n;
  endfunction : eic_settle_len
endpackage : eic_pkg

// File: src/eic_settle_if.sv
// link between the sequencer and the oscillator settle timer
`timescale 1ns/1ps
`default_nettype none
interface eic_settle_if;
  logic start;
  logic [2:0] code;
  logic tick32;
  logic osc_en;
  logic ready;
  modport seq (output start, output code, output tick32,
               input osc_en, input ready);
  modport tmr (input start, input code, input tick32,
               output osc_en, output ready);
endinterface : eic_settle_if
`default_nettype wire

// File: src/eic_settle_timer.sv
// oscillator settle timer counted in slow clock periods
`timescale 1ns/1ps
`default_nettype none
module eic_settle_timer
  import eic_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // sequencer side
  eic_settle_if.tmr st
);
  logic [7:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic cont;

  assign cont = st.code > EIC_SETTLE_MAX_TIMED;

  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (st.start && !cont)
    begin
      cnt_d = eic_settle_len(st.code);
      busy_d = 1'b1;
    end
    else if (busy_q && st.tick32)
    begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01)
        busy_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  // continuous codes skip the wait and hold the oscillator on
  // ready ignores start, so the sequencer sees no loop through it
  assign st.ready = cont || !busy_q;
  assign st.osc_en = cont || busy_q;
endmodule : eic_settle_timer
`default_nettype wire

// File: src/eic_top.sv
// calibration and control register with event sequencing and pins
`timescale 1ns/1ps
`default_nettype none
module eic_top
  import eic_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // serial register port, mode 0, msb first
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // slow reference clock pin
  input wire logic clk32_in,
  // measurement engine, same clock domain
  input wire logic cmd_start_in,
  input wire logic cmd_stop_in,
  input wire logic cycle_done_in,
  input wire logic seq_done_in,
  input wire logic dir_upstream_in,
  input wire logic [3:0] other_irq_in,
  input wire logic irq_ack_in,
  output logic meas_run_out,
  output logic osc_en_out,
  // comparator and pins
  input wire logic comparator_in,
  output logic comparator_monitor_pin_out,
  output logic irq_n_out
);
  eic_settle_if sif ();

  // two-stage synchronisers; stage 1 is read only by stage 2
  logic [4:0] s1_q, s2_q;
  logic sclk_prev_q, c32_prev_q;
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // idle levels: serial clock low, chip select high, so no false edge
      s1_q <= 5'h02;
      s2_q <= 5'h02;
      sclk_prev_q <= 1'b0;
      c32_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {comparator_in, clk32_in, spi_mosi_in, spi_cs_n_in,
               spi_sclk_in};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[0];
      c32_prev_q <= s2_q[3];
    end
  end

  logic sclk_rise, cs_n, mosi, cmp_s;
  assign sclk_rise = s2_q[0] && !sclk_prev_q;
  assign cs_n = s2_q[1];
  assign mosi = s2_q[2];
  assign cmp_s = s2_q[4];

  // serial frame: opcode byte then one 16-bit word
  logic [4:0] bit_q, bit_d;
  logic [15:0] sh_q, sh_d, tx_q, tx_d, reg_q, reg_d;
  logic [7:0] op_q, op_d;
  logic rd_q, rd_d;

  always_comb
  begin
    bit_d = bit_q;
    sh_d = sh_q;
    op_d = op_q;
    tx_d = tx_q;
    rd_d = rd_q;
    reg_d = reg_q;
    if (cs_n)
    begin
      bit_d = 5'h00;
      rd_d = 1'b0;
    end
    else if (sclk_rise)
    begin
      sh_d = {sh_q[14:0], mosi};
      if (bit_q < 5'(EIC_FRAME_BITS))
        bit_d = bit_q + 5'h01;
      if (bit_q == 5'(EIC_OPC_BITS - 1))
      begin
        op_d = {sh_q[6:0], mosi};
        rd_d = ({sh_q[6:0], mosi} == EIC_OP_READ);
        tx_d = reg_q;
      end
      else if (bit_q >= 5'(EIC_OPC_BITS))
        tx_d = {tx_q[14:0], 1'b0};
      if (bit_q == 5'(EIC_FRAME_BITS - 1) && op_q == EIC_OP_WRITE)
        reg_d = {sh_q[14:0], mosi} & EIC_REG_MASK;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_q <= 5'h00;
      sh_q <= 16'h0000;
      op_q <= 8'h00;
      tx_q <= 16'h0000;
      rd_q <= 1'b0;
      reg_q <= EIC_REG_RESET;
    end
    else
    begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      op_q <= op_d;
      tx_q <= tx_d;
      rd_q <= rd_d;
      reg_q <= reg_d;
    end
  end

  assign spi_miso_out = tx_q[15];
  assign spi_miso_oe_out = rd_q && !cs_n;

  // sequencer: settle, measure, then repeat or stop
  eic_state_t st_q, st_d;
  logic irq_q, irq_d, run_q, run_d, settle_go;
  logic per_cycle, repeat_en;
  assign per_cycle = reg_q[EIC_BIT_PER_CYCLE];
  assign repeat_en = reg_q[EIC_BIT_REPEAT];

  always_comb
  begin
    st_d = st_q;
    settle_go = 1'b0;
    irq_d = irq_q;
    if (irq_ack_in)
      irq_d = 1'b0;
    case (st_q)
      EIC_IDLE:
        if (cmd_start_in)
        begin
          st_d = EIC_SETTLE;
          settle_go = 1'b1;
        end
      EIC_SETTLE:
        if (cmd_stop_in)
          st_d = EIC_IDLE;
        else if (sif.ready)
          st_d = EIC_MEASURE;
      EIC_MEASURE:
        if (cmd_stop_in)
          st_d = EIC_IDLE;
        else if (seq_done_in)
        begin
          // one sequence unless repeat is enabled
          if (repeat_en)
          begin
            st_d = EIC_SETTLE;
            settle_go = 1'b1;
          end
          else
            st_d = EIC_IDLE;
        end
      default:
        st_d = EIC_IDLE;
    endcase
    // the event wins over an acknowledge in the same cycle
    if (st_q == EIC_MEASURE && !cmd_stop_in)
    begin
      if (per_cycle && cycle_done_in)
        irq_d = 1'b1;
      else if (!per_cycle && seq_done_in)
        irq_d = 1'b1;
    end
    run_d = (st_d == EIC_MEASURE);
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= EIC_IDLE;
      irq_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      irq_q <= irq_d;
      run_q <= run_d;
    end
  end

  assign sif.start = settle_go;
  assign sif.code = reg_q[EIC_SETTLE_LSB +: 3];
  assign sif.tick32 = s2_q[3] && !c32_prev_q;

  eic_settle_timer u_settle (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .st(sif.tmr)
  );

  // pin outputs registered so they never glitch
  logic irq_n_q, irq_n_d, mon_q, mon_d;
  always_comb
  begin
    irq_n_d = !(reg_q[EIC_BIT_IRQ_EN] &&
                (irq_q || (|other_irq_in)));
    mon_d = 1'b0;
    if (reg_q[EIC_BIT_MON_EN])
      mon_d = reg_q[EIC_BIT_MON_SEL] ? cmp_s : dir_upstream_in;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_n_q <= 1'b1;
      mon_q <= 1'b0;
    end
    else
    begin
      irq_n_q <= irq_n_d;
      mon_q <= mon_d;
    end
  end

  assign irq_n_out = irq_n_q;
  assign comparator_monitor_pin_out = mon_q;
  assign meas_run_out = run_q;
  // held on from settle into measure so the settled oscillator never drops
  assign osc_en_out = sif.osc_en || (st_q != EIC_IDLE);
endmodule : eic_top
`default_nettype wire

// File: verification/eic_spi_host.sv
// serial host model driving 24-bit register frames
`timescale 1ns/1ps
`default_nettype none
module eic_spi_host
#(
  parameter int HALF = 4
)
(
  input wire logic mclk_in,
  input wire logic miso_in,
  output var logic sclk_out = 1'b0,
  output var logic cs_n_out = 1'b1,
  output var logic mosi_out = 1'b0
);
  task automatic wt(input int k);
    repeat (k) @(posedge mclk_in);
    #5;
  endtask : wt

  task automatic xfer(input logic [7:0] op, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [23:0] f;
    f = {op, wd};
    rd = 16'h0000;
    cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      mosi_out = f[i];
      wt(HALF);
      if (i < 16)
        rd[i] = miso_in;
      sclk_out = 1'b1;
      wt(HALF);
      sclk_out = 1'b0;
    end
    wt(HALF);
    cs_n_out = 1'b1;
    // released line shows the inverse so a stale bit is never mistaken
    mosi_out = ~mosi_out;
    wt(HALF);
  endtask : xfer
endmodule : eic_spi_host
`default_nettype wire

// File: verification/eic_top_props.sv
// assertions on the engine and interrupt pins of eic_top
`timescale 1ns/1ps
`default_nettype none
module eic_top_props
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic spi_cs_n_in,
  input wire logic cmd_start_in,
  input wire logic cmd_stop_in,
  input wire logic cycle_done_in,
  input wire logic seq_done_in,
  input wire logic [3:0] other_irq_in,
  input wire logic irq_ack_in,
  input wire logic meas_run_out,
  input wire logic osc_en_out,
  input wire logic irq_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire logic quiet = other_irq_in == 4'h0 && !cycle_done_in && !seq_done_in;

  a_run_osc: assert property
    ($rose(meas_run_out) |-> $past(osc_en_out, 2))
    else $error("oscillator not settled before run");
  a_osc_first: assert property
    ($rose(meas_run_out) |-> $past(osc_en_out))
    else $error("run began before oscillator");
  a_seq_end: assert property
    (meas_run_out && seq_done_in |-> ##[1:2] !meas_run_out)
    else $error("sequence end ignored");
  a_stop_end: assert property
    (meas_run_out && cmd_stop_in |-> ##[1:2] !meas_run_out)
    else $error("stop ignored");
  a_no_restart: assert property
    (meas_run_out && cmd_start_in && !cmd_stop_in && !seq_done_in
      |=> meas_run_out)
    else $error("start disturbed a run");
  a_irq_cause: assert property
    ($fell(irq_n_out) && $past(spi_cs_n_in, 6) |-> $past(|other_irq_in)
      || $past(cycle_done_in, 2) || $past(seq_done_in, 2))
    else $error("interrupt without source");
  a_irq_release: assert property
    (irq_ack_in && quiet ##1 quiet |=> irq_n_out)
    else $error("interrupt held after ack");
  a_irq_hold: assert property
    (!irq_n_out && (|other_irq_in) && spi_cs_n_in |=> !irq_n_out)
    else $error("active source dropped");

  c_run: cover property ($rose(meas_run_out));
  c_irq: cover property ($fell(irq_n_out));
  c_ack: cover property (irq_ack_in && !irq_n_out);
endmodule : eic_top_props
`default_nettype wire

// File: verification/eic_top_test.sv
// self-checking bench for eic_top
`timescale 1ns/1ps
`default_nettype none
module eic_top_test;
  import eic_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clk32 = 1'b0;
  logic start = 1'b0, stop = 1'b0, cyc_d = 1'b0, seq_d = 1'b0;
  logic dir = 1'b0, ack = 1'b0, cmp_in = 1'b0;
  logic [3:0] oirq = 4'h0;
  wire logic sclk, cs_n, mosi, miso, oe, run, osc, mon, irq_n;
  // an undriven data line reads as the inverse of the last bit shown
  wire logic miso_line = oe ? miso : ~miso;
  logic [15:0] rd;
  int errors = 0, tests_run = 0, cyc = 0, n;
  localparam int WAITS [5] = '{16, 48, 96, 128, 168};

  always #25 mclk_in = ~mclk_in;
  // slow clock sped up: settle counts are in its edges, not in time
  always #1000 clk32 = ~clk32;

  eic_spi_host host (.mclk_in(mclk_in), .miso_in(miso_line), .sclk_out(sclk),
    .cs_n_out(cs_n), .mosi_out(mosi));
  eic_top dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(oe), .clk32_in(clk32), .cmd_start_in(start),
    .cmd_stop_in(stop), .cycle_done_in(cyc_d), .seq_done_in(seq_d),
    .dir_upstream_in(dir), .other_irq_in(oirq), .irq_ack_in(ack),
    .meas_run_out(run), .osc_en_out(osc), .comparator_in(cmp_in),
    .comparator_monitor_pin_out(mon), .irq_n_out(irq_n));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string nm);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #5;
  endtask : tick

  task automatic wr(input logic [15:0] v);
    host.xfer(EIC_OP_WRITE, v, rd);
  endtask : wr

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  task automatic close_out;
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    tick(3);
    nrst_in = 1'b1;
    tick(3);
    host.xfer(EIC_OP_READ, 16'h0000, rd);
    chk(rd, 16'h0000, "reset value");
    wr(16'hFFFF);
    host.xfer(EIC_OP_READ, 16'h0000, rd);
    chk(rd, 16'h0FFF, "reserved bits");
    for (int c = 0; c < 5; c++)
    begin
      wr(16'(c << 4));
      // start well clear of a slow clock edge so no tick is half counted
      @(posedge clk32);
      tick(8);
      pulse(start);
      n = 0;
      while (run !== 1'b1 && n < 200)
      begin
        @(posedge clk32);
        tick(8);
        n++;
      end
      chk(16'(n), 16'(WAITS[c]), "settle edges");
      pulse(seq_d);
      tick(3);
      chk({15'h0, run}, 16'h0000, "single sequence");
      chk({15'h0, irq_n}, 16'h0001, "irq disabled");
    end
    for (int c = 5; c < 8; c++)
    begin
      wr(16'(c << 4));
      chk({15'h0, osc}, 16'h0001, "osc continuous");
    end
    wr(16'h02F0);
    pulse(ack);
    pulse(start);
    tick(3);
    chk({15'h0, run}, 16'h0001, "run without wait");
    pulse(start);
    pulse(cyc_d);
    tick(2);
    chk({15'h0, irq_n}, 16'h0000, "per cycle irq");
    pulse(ack);
    tick(2);
    chk({15'h0, irq_n}, 16'h0001, "irq cleared");
    wr(16'h0270);
    pulse(cyc_d);
    tick(2);
    chk({15'h0, irq_n}, 16'h0001, "no cycle irq");
    pulse(seq_d);
    tick(2);
    chk({15'h0, irq_n}, 16'h0000, "sequence irq");
    pulse(ack);
    oirq = 4'h4;
    tick(2);
    chk({15'h0, irq_n}, 16'h0000, "other source");
    oirq = 4'h0;
    pulse(start);
    tick(3);
    pulse(stop);
    wr(16'h0070);
    oirq = 4'hF;
    tick(3);
    chk({15'h0, irq_n}, 16'h0001, "pin disabled");
    oirq = 4'h0;
    wr(16'h0170);
    pulse(start);
    tick(3);
    pulse(seq_d);
    tick(2);
    chk({15'h0, run}, 16'h0001, "repeat sequence");
    pulse(stop);
    tick(2);
    chk({15'h0, run}, 16'h0000, "repeat stopped");
    wr(16'h0C00);
    cmp_in = 1'b1;
    tick(4);
    chk({15'h0, mon}, 16'h0001, "monitor comparator");
    wr(16'h0800);
    dir = 1'b1;
    tick(2);
    chk({15'h0, mon}, 16'h0001, "monitor direction");
    dir = 1'b0;
    tick(2);
    chk({15'h0, mon}, 16'h0000, "monitor direction");
    wr(16'h0400);
    chk({15'h0, mon}, 16'h0000, "monitor off");
    close_out();
  end
endmodule : eic_top_test

bind eic_top eic_top_props props (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .spi_cs_n_in(spi_cs_n_in), .cmd_start_in(cmd_start_in),
  .cmd_stop_in(cmd_stop_in), .cycle_done_in(cycle_done_in),
  .seq_done_in(seq_done_in), .other_irq_in(other_irq_in),
  .irq_ack_in(irq_ack_in), .meas_run_out(meas_run_out),
  .osc_en_out(osc_en_out), .irq_n_out(irq_n_out));
`default_nettype wire
